// ==== hdl/dcrm_bit_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
// picks one system address bit at base plus field, zero when out of range
module dcrm_bit_sel #(
    parameter int         BASE = 0,
    parameter logic [3:0] MAXV = 4'h7
) (
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  sel,
    output logic             bit_out
);
    logic [4:0] idx;

    always_comb begin
        idx     = 5'(BASE) + {1'b0, sel}; // [RULE_08]
        bit_out = 1'b0;
        if (sel <= MAXV) begin // [RULE_05] [RULE_12]
            bit_out = addr[idx];
        end
    end
endmodule : dcrm_bit_sel
`default_nettype wire

// ==== hdl/dcrm_mapper.sv ====
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcrm_mapper
    import dcrm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [31:0] sys_addr,
    input  wire logic        addr_valid,
    input  wire logic        auto_precharge,
    output logic             map_valid,
    output logic [14:0]      dram_row,
    output logic [13:0]      dram_col
);
    // configuration registers
    logic [15:0] column_map_upper;
    logic [15:0] row_map_low;
    logic [7:0]  row_map_high;
    logic [1:0]  dq_width_select;
    logic [15:0] next_column_map_upper;
    logic [15:0] next_row_map_low;
    logic [7:0]  next_row_map_high;
    logic [1:0]  next_dq_width_select;

    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    logic        next_map_valid;
    logic [14:0] next_dram_row;
    logic [13:0] next_dram_col;

    logic [3:0]  col_sel_base8;
    logic [3:0]  col_sel_base9;
    logic [3:0]  col_sel_base10;
    logic [3:0]  col_sel_base11;
    logic [3:0]  row0_sel;
    logic [3:0]  row1_sel;
    logic [3:0]  row_mid_sel;
    logic [3:0]  row12_sel;
    logic [3:0]  row13_sel;
    logic [3:0]  row14_sel;

    logic [3:0]  col_field [COL_FIELDS];
    logic [3:0]  row_field [ROW_BITS];
    logic [COL_FIELDS-1:0] col_pick;
    logic [ROW_BITS-1:0]   row_pick;
    logic [13:0] col_map_now;

    logic        apb_access;
    logic        apb_write;
    logic        addr_hit;

    assign col_sel_base8  = column_map_upper[POS_COL_B8 +: 4];
    assign col_sel_base9  = column_map_upper[POS_COL_B9 +: 4];
    assign col_sel_base10 = column_map_upper[POS_COL_B10 +: 4];
    assign col_sel_base11 = column_map_upper[POS_COL_B11 +: 4];
    assign row0_sel       = row_map_low[POS_ROW0 +: 4];
    assign row1_sel       = row_map_low[POS_ROW1 +: 4];
    assign row_mid_sel    = row_map_low[POS_ROW_MID +: 4];
    assign row12_sel      = row_map_low[POS_ROW12 +: 4];
    assign row13_sel      = row_map_high[POS_ROW13-POS_ROW_HIGH_LSB +: 4];
    assign row14_sel      = row_map_high[POS_ROW14-POS_ROW_HIGH_LSB +: 4];

    // apb slave: one wait state, answer registered
    assign apb_access = psel && penable && !pready;
    assign apb_write  = psel && penable && pready && pwrite;
    assign addr_hit   = (paddr == OFS_COL_MAP_UPPER) ||
                        (paddr == OFS_ROW_MAP_LOW) ||
                        (paddr == OFS_ROW_MAP_HIGH) ||
                        (paddr == OFS_WIDTH_CFG);

    always_comb begin
        next_pready  = apb_access;
        next_pslverr = apb_access && !addr_hit;
        next_prdata  = 32'h00000000;
        if (apb_access && !pwrite) begin
            // reserved bits read as zero
            unique case (paddr)
                OFS_COL_MAP_UPPER: next_prdata = {16'h0000, column_map_upper};
                OFS_ROW_MAP_LOW:   next_prdata = {16'h0000, row_map_low};
                OFS_ROW_MAP_HIGH:  next_prdata = {20'h00000, row_map_high,
                                                  4'h0};
                OFS_WIDTH_CFG:     next_prdata = {30'h00000000,
                                                  dq_width_select};
                default:           next_prdata = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        next_column_map_upper = column_map_upper;
        next_row_map_low      = row_map_low;
        next_row_map_high     = row_map_high;
        next_dq_width_select  = dq_width_select;
        if (apb_write) begin
            unique case (paddr)
                OFS_COL_MAP_UPPER: next_column_map_upper = pwdata[15:0];
                OFS_ROW_MAP_LOW:   next_row_map_low      = pwdata[15:0];
                OFS_ROW_MAP_HIGH:  next_row_map_high     = pwdata[11:4];
                OFS_WIDTH_CFG:     next_dq_width_select  = pwdata[1:0];
                default:           next_dq_width_select  = dq_width_select;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready           <= 1'b0;
            prdata           <= 32'h00000000;
            pslverr          <= 1'b0;
            column_map_upper <= RST_COL_MAP_UPPER;
            row_map_low      <= RST_ROW_MAP_LOW;
            row_map_high     <= RST_ROW_MAP_HIGH;
            dq_width_select  <= RST_WIDTH_CFG;
        end else begin
            pready           <= next_pready;
            prdata           <= next_prdata;
            pslverr          <= next_pslverr;
            column_map_upper <= next_column_map_upper;
            row_map_low      <= next_row_map_low;
            row_map_high     <= next_row_map_high;
            dq_width_select  <= next_dq_width_select;
        end
    end

    // field routing per row bit
    always_comb begin
        col_field[0] = col_sel_base8;
        col_field[1] = col_sel_base9;
        col_field[2] = col_sel_base10;
        col_field[3] = col_sel_base11;
        for (int i = 0; i < ROW_BITS; i++) begin
            row_field[i] = row_mid_sel; // [RULE_11]
        end
        row_field[0]  = row0_sel;  // [RULE_09]
        row_field[1]  = row1_sel;  // [RULE_10]
        row_field[12] = row12_sel; // [RULE_12]
        row_field[13] = row13_sel; // [RULE_13]
        row_field[14] = row14_sel; // [RULE_14]
    end

    // base is 6 plus row index for every row bit
    for (genvar r = 0; r < ROW_BITS; r++) begin : g_row
        dcrm_bit_sel #(
            .BASE (ROW_BASE_FIRST + r),
            .MAXV (ROW_MAX_VAL)
        ) u_sel (
            .addr    (sys_addr),
            .sel     (row_field[r]),
            .bit_out (row_pick[r])
        ); // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
    end

    for (genvar c = 0; c < COL_FIELDS; c++) begin : g_col
        dcrm_bit_sel #(
            .BASE (COL_BASE_FIRST + c),
            .MAXV (COL_MAX_VAL)
        ) u_sel (
            .addr    (sys_addr),
            .sel     (col_field[c]),
            .bit_out (col_pick[c])
        ); // [RULE_05] [RULE_08]
    end

    // column placement shifts with bus width; reserved width maps only auto-precharge to bit 10
    always_comb begin
        col_map_now             = 14'h0000;
        col_map_now[COL_AP_BIT] = auto_precharge; // [RULE_06]
        unique case (dq_width_select) // [RULE_16]
            DCRM_W_FULL: begin
                col_map_now[9]  = col_pick[0]; // [RULE_01]
                col_map_now[11] = col_pick[1]; // [RULE_02]
                col_map_now[12] = col_pick[2]; // [RULE_03]
                col_map_now[13] = col_pick[3]; // [RULE_04]
            end
            DCRM_W_HALF: begin
                col_map_now[11] = col_pick[0]; // [RULE_01]
                col_map_now[12] = col_pick[1]; // [RULE_02]
                col_map_now[13] = col_pick[2]; // [RULE_03]
            end
            DCRM_W_QUARTER: begin
                col_map_now[12] = col_pick[0]; // [RULE_01]
                col_map_now[13] = col_pick[1]; // [RULE_02]
            end
            DCRM_W_RSVD: begin
                col_map_now[COL_AP_BIT] = auto_precharge;
            end
        endcase
    end

    // one registered stage from system address to dram address
    always_comb begin
        next_map_valid = addr_valid; // [RULE_17]
        next_dram_row  = dram_row;
        next_dram_col  = dram_col;
        if (addr_valid) begin
            next_dram_row = row_pick;
            next_dram_col = col_map_now;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            map_valid <= 1'b0;
            dram_row  <= 15'h0000;
            dram_col  <= 14'h0000;
        end else begin
            map_valid <= next_map_valid;
            dram_row  <= next_dram_row;
            dram_col  <= next_dram_col;
        end
    end

    // helper copies of the inputs of the previous cycle
    logic [31:0] h_addr;
    logic        h_ap;
    logic [15:0] h_col;
    logic [15:0] h_rlo;
    logic [7:0]  h_rhi;
    logic [1:0]  h_w;

    always_ff @(posedge ref_clk) begin
        h_addr <= sys_addr;
        h_ap   <= auto_precharge;
        h_col  <= column_map_upper;
        h_rlo  <= row_map_low;
        h_rhi  <= row_map_high;
        h_w    <= dq_width_select;
    end

    sequence s_take;
        addr_valid;
    endsequence

    sequence s_take_full;
        addr_valid && dq_width_select == DCRM_W_FULL;
    endsequence

    property p_col8_full;
        @(posedge ref_clk) disable iff (rst)
        s_take_full ##1 (h_col[15:12] <= 4'h7) |->
            dram_col[9] == h_addr[8 + h_col[15:12]];
    endproperty
    a_col8_full: assert property (p_col8_full) // [RULE_01]
        else $error("col bit 9 not from base 8 field");

    property p_col9_quarter;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && dq_width_select == DCRM_W_QUARTER
            && col_sel_base9 <= 4'h7 |=>
            dram_col[13] == h_addr[9 + h_col[11:8]];
    endproperty
    a_col9_quarter: assert property (p_col9_quarter) // [RULE_02]
        else $error("quarter col bit 13 not from base 9 field");

    property p_col10_half;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && dq_width_select == DCRM_W_HALF
            && col_sel_base10 <= 4'h7 |=>
            dram_col[13] == h_addr[10 + h_col[7:4]];
    endproperty
    a_col10_half: assert property (p_col10_half) // [RULE_03]
        else $error("half col bit 13 not from base 10 field");

    property p_col11_full;
        @(posedge ref_clk) disable iff (rst)
        s_take_full ##1 (h_col[3:0] <= 4'h7) |->
            dram_col[13] == h_addr[11 + h_col[3:0]];
    endproperty
    a_col11_full: assert property (p_col11_full) // [RULE_04]
        else $error("full col bit 13 not from base 11 field");

    property p_col_off;
        @(posedge ref_clk) disable iff (rst)
        s_take_full ##1 (h_col[15:12] == 4'hF) |-> dram_col[9] == 1'b0;
    endproperty
    a_col_off: assert property (p_col_off) // [RULE_05]
        else $error("disabled col bit 9 not zero");

    property p_ap_bit;
        @(posedge ref_clk) disable iff (rst)
        s_take |=> dram_col[COL_AP_BIT] == h_ap;
    endproperty
    a_ap_bit: assert property (p_ap_bit) // [RULE_06]
        else $error("col bit 10 not auto-precharge");

    property p_row0;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && row0_sel <= 4'hB |=>
            dram_row[0] == h_addr[6 + h_rlo[15:12]];
    endproperty
    a_row0: assert property (p_row0) // [RULE_09]
        else $error("row bit 0 wrong source");

    property p_row1;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && row1_sel <= 4'hB |=>
            dram_row[1] == h_addr[7 + h_rlo[11:8]];
    endproperty
    a_row1: assert property (p_row1) // [RULE_10]
        else $error("row bit 1 wrong source");

    property p_row_mid;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && row_mid_sel <= 4'hB |=>
            dram_row[2] == h_addr[8 + h_rlo[7:4]] &&
            dram_row[11] == h_addr[17 + h_rlo[7:4]];
    endproperty
    a_row_mid: assert property (p_row_mid) // [RULE_11]
        else $error("row bits 2 to 11 wrong source");

    property p_row12;
        @(posedge ref_clk) disable iff (rst)
        s_take ##1 1'b1 |->
            dram_row[12] == ((h_rlo[3:0] == 4'hF) ? 1'b0 :
                             (h_rlo[3:0] <= 4'hB) ? h_addr[18 + h_rlo[3:0]] :
                             1'b0);
    endproperty
    a_row12: assert property (p_row12) // [RULE_12]
        else $error("row bit 12 wrong");

    property p_row13;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && row13_sel <= 4'hB |=>
            dram_row[13] == h_addr[19 + h_rhi[7:4]];
    endproperty
    a_row13: assert property (p_row13) // [RULE_13]
        else $error("row bit 13 wrong source");

    property p_row14_off;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && row14_sel == 4'hF |=> dram_row[14] == 1'b0;
    endproperty
    a_row14_off: assert property (p_row14_off) // [RULE_14]
        else $error("disabled row bit 14 not zero");

    property p_rsvd_width;
        @(posedge ref_clk) disable iff (rst)
        addr_valid && dq_width_select == DCRM_W_RSVD |=>
            dram_col[13:11] == 3'h0 && dram_col[9] == 1'b0;
    endproperty
    a_rsvd_width: assert property (p_rsvd_width) // [RULE_16]
        else $error("reserved width still maps columns");

    property p_latency;
        @(posedge ref_clk) disable iff (rst)
        map_valid == $past(addr_valid);
    endproperty
    a_latency: assert property (p_latency) // [RULE_17]
        else $error("map_valid not one cycle after addr_valid");

endmodule : dcrm_mapper
`default_nettype wire

// ==== hdl/dcrm_pkg.sv ====
// Behaviour
// RULE_01: column field base 8 drives column bit 9 at full, 11 at half and 12 at quarter width.
// RULE_02: column field base 9 drives column bit 11 at full, 12 at half and 13 at quarter width.
// RULE_03: column field base 10 drives column bit 12 at full and 13 at half width, unused at quarter.
// RULE_04: column field base 11 drives column bit 13 at full width only, unused otherwise.
// RULE_05: a column field holding 15 forces its column bit to zero.
// RULE_06: column bit 10 carries auto-precharge and never takes a system address bit.
// RULE_07: software writes column fields only with 0 to 7 or 15.
// RULE_08: each selected system address bit is the field's fixed base plus the field value.
// RULE_09: row bit 0 takes system address bit 6 plus its field, field 0 to 11.
// RULE_10: row bit 1 takes system address bit 7 plus its field, field 0 to 11.
// RULE_11: one shared field maps row bits 2 to 11 with bases 8 up to 17.
// RULE_12: row bit 12 has base 18, values 0 to 11, and 15 forces it to zero.
// RULE_13: row bit 13 has base 19, values 0 to 11, and 15 forces it to zero.
// RULE_14: row bit 14 has base 20, values 0 to 11, and 15 forces it to zero.
// RULE_15: software keeps reserved bits unchanged across read-modify-write.
// RULE_16: width code 00 is full, 01 half, 10 quarter, and 11 is reserved.
// RULE_17: row and column addresses come from each system address with current settings.
`default_nettype none
package dcrm_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_COL_MAP_UPPER = 12'h000;
    localparam logic [11:0] OFS_ROW_MAP_LOW   = 12'h004;
    localparam logic [11:0] OFS_ROW_MAP_HIGH  = 12'h008;
    localparam logic [11:0] OFS_WIDTH_CFG     = 12'h00C;

    // reset values
    localparam logic [15:0] RST_COL_MAP_UPPER = 16'h0000;
    localparam logic [15:0] RST_ROW_MAP_LOW   = 16'h0000;
    localparam logic [7:0]  RST_ROW_MAP_HIGH  = 8'h00;
    localparam logic [1:0]  RST_WIDTH_CFG     = 2'h0;

    // field positions (low bit of each 4-bit field)
    localparam int POS_COL_B8  = 12;
    localparam int POS_COL_B9  = 8;
    localparam int POS_COL_B10 = 4;
    localparam int POS_COL_B11 = 0;
    localparam int POS_ROW0    = 12;
    localparam int POS_ROW1    = 8;
    localparam int POS_ROW_MID = 4;
    localparam int POS_ROW12   = 0;
    localparam int POS_ROW13   = 8;
    localparam int POS_ROW14   = 4;
    // row_map_high stores only bits [11:4]
    localparam int POS_ROW_HIGH_LSB = 4;

    // internal bases
    localparam int COL_BASE_FIRST = 8;
    localparam int ROW_BASE_FIRST = 6;
    localparam int COL_FIELDS     = 4;
    localparam int ROW_BITS       = 15;
    localparam int COL_BITS       = 14;

    // field value limits
    localparam logic [3:0] COL_MAX_VAL = 4'h7;
    localparam logic [3:0] ROW_MAX_VAL = 4'hB;
    localparam logic [3:0] SEL_OFF     = 4'hF;

    // column bit positions
    localparam int COL_AP_BIT = 10;

    // data bus width codes
    typedef enum logic [1:0] {
        DCRM_W_FULL    = 2'h0,
        DCRM_W_HALF    = 2'h1,
        DCRM_W_QUARTER = 2'h2,
        DCRM_W_RSVD    = 2'h3
    } dcrm_width_t;

endpackage : dcrm_pkg
`default_nettype wire

// ==== verification/dcrm_mapper_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcrm_mapper_tb
    import dcrm_pkg::*;
    ();

    localparam int          CYC_MAX = 20000;
    localparam logic [11:0] OFS [4] = '{OFS_COL_MAP_UPPER, OFS_ROW_MAP_LOW,
                                        OFS_ROW_MAP_HIGH, OFS_WIDTH_CFG};
    localparam logic [31:0] MSK [4] = '{32'h0000FFFF, 32'h0000FFFF,
                                        32'h00000FF0, 32'h00000003};
    // col fields only 0..7 or 15
    localparam logic [39:0] SETS [4] = '{40'h0, 40'h7777BBBBBB,
                                         40'hFFFF000FFF, 40'h351629470F};

    logic        ref_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] sys_addr;
    logic        addr_valid;
    logic        auto_precharge;
    logic        map_valid;
    logic [14:0] dram_row;
    logic [13:0] dram_col;
    logic [39:0] cfg;
    logic [1:0]  wcfg;
    int          fails;
    int          n_checks;
    int          cyc = 0;

    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    dcrm_mapper dcrm_mapper_i (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .pready         (pready),
        .prdata         (prdata),
        .pslverr        (pslverr),
        .sys_addr       (sys_addr),
        .addr_valid     (addr_valid),
        .auto_precharge (auto_precharge),
        .map_valid      (map_valid),
        .dram_row       (dram_row),
        .dram_col       (dram_col)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_MAX) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk_reg(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    task automatic chk_map(input string nm, input logic [14:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_map

    task automatic chk_bit(input string nm, input logic e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        chk_reg("apb_wait", 32'h00000002, n);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic pick(logic [31:0] a, int b, logic [3:0] v,
                                  int mx);
        return (v <= mx) ? a[b + v] : 1'b0;
    endfunction : pick

    // {row, 1'b0, col} from the model's copy of the fields
    function automatic logic [29:0] exp_map(logic [31:0] a, logic ap);
        logic [14:0] r;
        logic [13:0] c;
        logic        p8, p9, p10, p11;
        r[0]  = pick(a, 6, cfg[23:20], 11);
        r[1]  = pick(a, 7, cfg[19:16], 11);
        for (int i = 2; i < 12; i++) r[i] = pick(a, 6 + i, cfg[15:12], 11);
        r[12] = pick(a, 18, cfg[11:8], 11);
        r[13] = pick(a, 19, cfg[7:4], 11);
        r[14] = pick(a, 20, cfg[3:0], 11);
        p8  = pick(a, 8, cfg[39:36], 7);
        p9  = pick(a, 9, cfg[35:32], 7);
        p10 = pick(a, 10, cfg[31:28], 7);
        p11 = pick(a, 11, cfg[27:24], 7);
        c = '0;
        c[10] = ap;
        case (wcfg)
            2'h0: {c[13], c[12], c[11], c[9]} = {p11, p10, p9, p8};
            2'h1: {c[13], c[12], c[11]} = {p10, p9, p8};
            2'h2: {c[13], c[12]} = {p9, p8};
            default: ;
        endcase
        return {r, 1'b0, c};
    endfunction : exp_map

    task automatic t_reset();
        logic [31:0] rd;
        logic        er;
        @(posedge ref_clk);
        chk_bit("map_valid_rst", 1'b0, map_valid);
        chk_map("row_rst", 15'h0, dram_row);
        chk_map("col_rst", 15'h0, {1'b0, dram_col});
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, OFS[i], 32'h0, rd, er);
            chk_reg($sformatf("reg_%h", OFS[i]), 32'h0, rd);
        end
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] rd;
        logic        er;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS[i], 32'hFFFFFFFF, rd, er);
            apb(1'b0, OFS[i], 32'h0, rd, er);
            chk_reg($sformatf("reg_%h", OFS[i]), MSK[i], rd);
            chk_bit("reg_err", 1'b0, er);
        end
        apb(1'b1, 12'h010, 32'hFFFFFFFF, rd, er);
        chk_bit("unmapped_err", 1'b1, er);
        apb(1'b0, 12'h002, 32'h0, rd, er);
        chk_bit("misaligned_err", 1'b1, er);
        chk_reg("misaligned_data", 32'h0, rd);
    endtask : t_regs

    // reserved bits written as read back (zero)
    task automatic set_cfg(input logic [39:0] s, input logic [1:0] w);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, OFS_COL_MAP_UPPER, {16'h0, s[39:24]}, rd, er);
        apb(1'b1, OFS_ROW_MAP_LOW, {16'h0, s[23:8]}, rd, er);
        apb(1'b1, OFS_ROW_MAP_HIGH, {20'h0, s[7:0], 4'h0}, rd, er);
        apb(1'b1, OFS_WIDTH_CFG, {30'h0, w}, rd, er);
        cfg  = s;
        wcfg = w;
    endtask : set_cfg

    task automatic check_map(input logic [29:0] e);
        chk_bit("map_valid", 1'b1, map_valid);
        chk_bit("col_ap", e[10], dram_col[10]);
        chk_map("col", e[14:0], {1'b0, dram_col});
        chk_map("row", e[29:15], dram_row);
    endtask : check_map

    // back-to-back requests: walking ones then two dense patterns
    task automatic map_burst();
        logic [29:0] ex [35];
        logic [31:0] a;
        for (int i = 0; i < 37; i++) begin
            @(posedge ref_clk);
            if (i >= 2) check_map(ex[i - 2]);
            if (i < 35) begin
                a = (i < 32) ? (32'h1 << i) :
                    ((i == 32) ? 32'hFFFFFFFF : 32'hA5C3965A);
                ex[i] = exp_map(a, i[0]);
                sys_addr       <= a;
                auto_precharge <= i[0];
                addr_valid     <= 1'b1;
            end else begin
                addr_valid <= 1'b0;
            end
        end
        @(posedge ref_clk);
        chk_bit("map_valid_idle", 1'b0, map_valid);
        chk_map("row_hold", ex[34][29:15], dram_row);
    endtask : map_burst

    initial begin
        rst            = 1'b1;
        psel           = 1'b0;
        penable        = 1'b0;
        pwrite         = 1'b0;
        paddr          = 12'h000;
        pwdata         = 32'h0;
        sys_addr       = 32'h0;
        addr_valid     = 1'b0;
        auto_precharge = 1'b0;
        cfg            = 40'h0;
        wcfg           = 2'h0;
        fails          = 0;
        n_checks       = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        for (int s = 0; s < 4; s++) begin
            for (int w = 0; w < 4; w++) begin
                set_cfg(SETS[s], w[1:0]);
                map_burst();
            end
        end
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        print_verdict();
    end

endmodule : dcrm_mapper_tb
`default_nettype wire
